// file: hdl/crt_timer.sv
// 16-bit capture/auto-reload timer with prescaler and AXI4-Lite registers
// Behaviour
// [R1] capture mode: free 16-bit up count, overflow flag on wrap to zero
// [R2] capture mode with external enable: pin falling edge copies count to reload register
// [R3] that edge sets external flag; both flags can request an interrupt
// [R4] capture mode overflows every 65536 counts, each count prescale plus one cycles
// [R5] reset clears down-count enable, so auto-reload counts up
// [R6] mode 00 up: wrap at all ones, overflow flag, load reload value
// [R7] mode 00 with external enable: pin falling edge reloads and sets external flag
// [R8] mode 01 up: count zero to top, overflow flag, restart at zero
// [R9] mode 01 with external enable: pin falling edge clears count, sets external flag
// [R10] mode 01 top value double-buffered, new top used after next overflow
// [R11] down-count enabled in modes 00/01: pin high counts up, low counts down
// [R12] mode 00 down: underflow at reload value loads all ones; both set overflow flag
// [R13] down-count enabled: external flag toggles per over/underflow, no interrupt
// [R14] mode 01 down: underflow at zero loads top; up overflow at top loads zero
// [R15] modes 10/11 count zero up to top then down to zero, repeating
// [R16] dual-slope: external flag shows direction, zero up, one down
// [R17] dual-slope top value double-buffered, new top used after underflow at zero
// [R18] mode 10 flags overflow at zero only; mode 11 at top and zero
// [R19] down-count enable ignored in dual-slope modes
// [R20] dual-slope period is twice top, in prescaled counts
// [R21] run bit starts counting when set, stops when cleared
// [R22] trigger pin synchronised, falling edges found from successive samples
// [R23] trigger source holds each level at least two clock cycles
`timescale 1ns/10ps
`include "crt_params.svh"
module crt_timer #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external trigger / direction pin
  input wire logic trigger_pin,
  // interrupt request
  output logic irq_req
);

  crt_pkg::crt_ctrl_s ctrl;
  crt_pkg::crt_mode_s mode;
  crt_pkg::crt_trig_s trig;
  logic [15:0] count;
  logic [15:0] reload_capture;
  logic [15:0] top_active;
  logic [`CRT_PS_W-1:0] ps_cnt;
  logic overflow_flag;
  logic external_flag;
  logic tick;
  logic wr_fire;
  logic rd_fire;
  logic [ADDR_W-1:0] wr_addr_word;
  logic [ADDR_W-1:0] rd_addr_word;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_count;
  logic wr_reload;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic [15:0] next_count;
  logic ovf_evt;
  logic ext_set;
  logic ext_tog;
  logic turn_down;
  logic turn_up;
  logic load_top;
  logic cap_evt;
  logic dual_mode;

  // byte-lane merge of a register word with write data
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : wmerge

  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction : word_addr

  crt_trig_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .trigger_pin(trigger_pin),
    .trig(trig)
  );

  // ---------------- bus slave ----------------
  // address and data are taken together; one response outstanding at most
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_addr_word = word_addr(s_axi_awaddr);
  assign rd_addr_word = word_addr(s_axi_araddr);
  assign wr_ctrl = wr_fire & (wr_addr_word == ADDR_W'(`CRT_OFF_CTRL));
  assign wr_mode = wr_fire & (wr_addr_word == ADDR_W'(`CRT_OFF_MODE));
  assign wr_count = wr_fire & (wr_addr_word == ADDR_W'(`CRT_OFF_COUNT));
  assign wr_reload = wr_fire & (wr_addr_word == ADDR_W'(`CRT_OFF_RELOAD));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctrl | wr_mode | wr_count | wr_reload) ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    unique case (rd_addr_word)
      ADDR_W'(`CRT_OFF_CTRL): begin
        next_rdata[`CRT_CTRL_RUN] = ctrl.run;
        next_rdata[`CRT_CTRL_CAPTURE] = ctrl.capture;
        next_rdata[`CRT_CTRL_EXEN] = ctrl.exen;
        next_rdata[`CRT_CTRL_OVF] = overflow_flag;
        next_rdata[`CRT_CTRL_EXF] = external_flag;
      end
      ADDR_W'(`CRT_OFF_MODE): begin
        next_rdata[`CRT_MODE_CM_MSB:`CRT_MODE_CM_LSB] = mode.cmode;
        next_rdata[`CRT_MODE_DOWN_COUNT_ENABLE] = mode.down_count_enable;
        next_rdata[`CRT_MODE_PS_LSB +: `CRT_PS_W] = mode.prescale;
      end
      ADDR_W'(`CRT_OFF_COUNT): next_rdata[15:0] = count;
      ADDR_W'(`CRT_OFF_RELOAD): next_rdata[15:0] = reload_capture;
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CRT_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? `CRT_RESP_SLVERR : `CRT_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- software-owned configuration ----------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else if (wr_ctrl && s_axi_wstrb[0]) begin
      ctrl.run <= s_axi_wdata[`CRT_CTRL_RUN]; // R21
      ctrl.capture <= s_axi_wdata[`CRT_CTRL_CAPTURE];
      ctrl.exen <= s_axi_wdata[`CRT_CTRL_EXEN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode.cmode <= crt_pkg::CM_WRAP;
      mode.down_count_enable <= 1'b0; // R5
      mode.prescale <= '0;
    end else if (wr_mode) begin
      if (s_axi_wstrb[0]) begin
        mode.cmode <= crt_pkg::crt_cmode_e'(s_axi_wdata[`CRT_MODE_CM_MSB:`CRT_MODE_CM_LSB]);
        mode.down_count_enable <= s_axi_wdata[`CRT_MODE_DOWN_COUNT_ENABLE];
      end
      if (s_axi_wstrb[1]) begin
        mode.prescale <= s_axi_wdata[`CRT_MODE_PS_LSB +: `CRT_PS_W];
      end
    end
  end

  // ---------------- prescaler ----------------
  // one count every prescale+1 cycles; stopped timer restarts a fresh prescale period
  assign tick = ctrl.run & (ps_cnt == mode.prescale); // R4 R20 R21

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ps_cnt <= '0;
    end else if (!ctrl.run || tick) begin
      ps_cnt <= '0;
    end else begin
      ps_cnt <= ps_cnt + `CRT_PS_W'(1);
    end
  end

  // ---------------- count engine ----------------
  assign dual_mode = ~ctrl.capture & ((mode.cmode == crt_pkg::CM_SLOPE1) | (mode.cmode == crt_pkg::CM_SLOPE2));

  always_comb begin
    next_count = count;
    ovf_evt = 1'b0;
    ext_set = 1'b0;
    ext_tog = 1'b0;
    turn_down = 1'b0;
    turn_up = 1'b0;
    load_top = 1'b0;
    cap_evt = 1'b0;
    if (ctrl.capture) begin
      if (tick) begin
        next_count = count + 16'h0001; // R1
        ovf_evt = (count == `CRT_COUNT_MAX); // R1 R4
      end
      if (trig.fall && ctrl.exen) begin
        cap_evt = 1'b1; // R2
        ext_set = 1'b1; // R3
      end
    end else if (dual_mode) begin
      // direction is held in the external flag; down-count enable is not looked at
      if (tick) begin // R19
        if (!external_flag) begin
          if (count == top_active) begin
            turn_down = 1'b1; // R15 R16
            next_count = (top_active == `CRT_COUNT_MIN) ? `CRT_COUNT_MIN : count - 16'h0001;
            ovf_evt = (mode.cmode == crt_pkg::CM_SLOPE2); // R18
          end else begin
            next_count = count + 16'h0001; // R15
          end
        end else begin
          if (count == `CRT_COUNT_MIN) begin
            turn_up = 1'b1; // R16
            load_top = 1'b1; // R17
            ovf_evt = 1'b1; // R18
            next_count = (reload_capture == `CRT_COUNT_MIN) ? `CRT_COUNT_MIN : 16'h0001; // R20
          end else begin
            next_count = count - 16'h0001; // R15
          end
        end
      end
    end else if (mode.down_count_enable) begin
      // pin level picks direction, the edge itself does nothing here
      if (tick) begin
        if (trig.level) begin // R11
          if (mode.cmode == crt_pkg::CM_WRAP) begin
            if (count == `CRT_COUNT_MAX) begin
              next_count = reload_capture; // R12
              ovf_evt = 1'b1;
              ext_tog = 1'b1; // R13
            end else begin
              next_count = count + 16'h0001;
            end
          end else begin
            if (count == top_active) begin
              next_count = `CRT_COUNT_MIN; // R14
              ovf_evt = 1'b1;
              ext_tog = 1'b1; // R13
              load_top = 1'b1; // R10
            end else begin
              next_count = count + 16'h0001;
            end
          end
        end else begin
          if (mode.cmode == crt_pkg::CM_WRAP) begin
            if (count == reload_capture) begin
              next_count = `CRT_COUNT_MAX; // R12
              ovf_evt = 1'b1;
              ext_tog = 1'b1; // R13
            end else begin
              next_count = count - 16'h0001;
            end
          end else begin
            if (count == `CRT_COUNT_MIN) begin
              next_count = top_active; // R14
              ovf_evt = 1'b1;
              ext_tog = 1'b1; // R13
            end else begin
              next_count = count - 16'h0001;
            end
          end
        end
      end
    end else begin
      if (tick) begin
        if (mode.cmode == crt_pkg::CM_WRAP) begin
          if (count == `CRT_COUNT_MAX) begin
            next_count = reload_capture; // R6
            ovf_evt = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end else begin
          if (count == top_active) begin
            next_count = `CRT_COUNT_MIN; // R8
            ovf_evt = 1'b1;
            load_top = 1'b1; // R10
          end else begin
            next_count = count + 16'h0001;
          end
        end
      end
      // the pin edge takes priority over a tick in the same cycle
      if (trig.fall && ctrl.exen) begin
        next_count = (mode.cmode == crt_pkg::CM_WRAP) ? reload_capture : `CRT_COUNT_MIN; // R7 R9
        ext_set = 1'b1; // R7 R9
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= `CRT_RST_COUNT;
    end else if (wr_count) begin
      count <= 16'(wmerge({16'h0000, count}, s_axi_wdata, s_axi_wstrb));
    end else begin
      count <= next_count;
    end
  end

  // capture beats a software write landing in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reload_capture <= `CRT_RST_RELOAD;
    end else if (cap_evt) begin
      reload_capture <= count; // R2
    end else if (wr_reload) begin
      reload_capture <= 16'(wmerge({16'h0000, reload_capture}, s_axi_wdata, s_axi_wstrb));
    end
  end

  // shadow top: follows software freely while stopped, else only at the period boundary
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      top_active <= `CRT_RST_RELOAD;
    end else if (!ctrl.run || load_top) begin
      top_active <= reload_capture; // R10 R17
    end
  end

  // ---------------- flags ----------------
  // hardware set wins over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag <= 1'b1; // R1 R6 R8 R12 R14 R18
    end else if (wr_ctrl && s_axi_wstrb[0]) begin
      overflow_flag <= s_axi_wdata[`CRT_CTRL_OVF];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      external_flag <= 1'b0;
    end else if (turn_down) begin
      external_flag <= 1'b1; // R16
    end else if (turn_up) begin
      external_flag <= 1'b0; // R16
    end else if (ext_set) begin
      external_flag <= 1'b1; // R3 R7 R9
    end else if (ext_tog) begin
      external_flag <= ~external_flag; // R13
    end else if (wr_ctrl && s_axi_wstrb[0]) begin
      external_flag <= s_axi_wdata[`CRT_CTRL_EXF];
    end
  end

  // external flag is a count bit or direction in up/down and dual-slope use, so it is kept off the request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= overflow_flag | (external_flag & (ctrl.capture | (~dual_mode & ~mode.down_count_enable))); // R3 R13
    end
  end

endmodule : crt_timer

// file: hdl/crt_params.svh
// register map, field positions, reset values and bus codes of the capture/reload timer
`ifndef CRT_PARAMS_SVH
`define CRT_PARAMS_SVH

`define CRT_OFF_CTRL 5'h00
`define CRT_OFF_MODE 5'h04
`define CRT_OFF_COUNT 5'h08
`define CRT_OFF_RELOAD 5'h0c

`define CRT_CTRL_RUN 0
`define CRT_CTRL_CAPTURE 1
`define CRT_CTRL_EXEN 2
`define CRT_CTRL_OVF 3
`define CRT_CTRL_EXF 4

`define CRT_MODE_CM_LSB 0
`define CRT_MODE_CM_MSB 1
`define CRT_MODE_DOWN_COUNT_ENABLE 2
`define CRT_MODE_PS_LSB 8

`define CRT_PS_W 4
`define CRT_COUNT_MAX 16'hffff
`define CRT_COUNT_MIN 16'h0000
`define CRT_RST_RELOAD 16'h0000
`define CRT_RST_COUNT 16'h0000

`define CRT_RESP_OKAY 2'h0
`define CRT_RESP_SLVERR 2'h2

`endif

// file: hdl/crt_pkg.sv
// types shared by the capture/reload timer files
package crt_pkg;

  typedef enum logic [1:0] {
    CM_WRAP,
    CM_TOP,
    CM_SLOPE1,
    CM_SLOPE2
  } crt_cmode_e;

  typedef struct packed {
    logic run;
    logic capture;
    logic exen;
  } crt_ctrl_s;

  typedef struct packed {
    crt_cmode_e cmode;
    logic down_count_enable;
    logic [3:0] prescale;
  } crt_mode_s;

  typedef struct packed {
    logic level;
    logic fall;
  } crt_trig_s;

endpackage : crt_pkg

// file: hdl/crt_trig_sync.sv
// trigger pin synchroniser and falling edge detector
`timescale 1ns/10ps
module crt_trig_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin and result
  input wire logic trigger_pin,
  output crt_pkg::crt_trig_s trig
);

  logic meta;
  logic sync;
  logic prev;

  // first stage feeds only the second; edge logic looks at the later stages
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= trigger_pin; // R22
      sync <= meta;
      prev <= sync;
    end
  end

  assign trig.level = sync;
  assign trig.fall = prev & ~sync; // R22

endmodule : crt_trig_sync

// file: tb/crt_timer_checker.sv
// bus protocol checker bound to the capture/reload timer
`timescale 1ns/10ps
`include "crt_params.svh"
module crt_timer_checker #(
  parameter int ADDR_W = 5
) (
  // watched ports
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_term: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("awready term wrong");
  a_w_pair: assert property (s_axi_wready == s_axi_awready) else $error("wready differs from awready");
  a_ar_term: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready term wrong");
  a_wr_code: assert property (s_wr_take |=> s_axi_bresp == ($past(s_axi_awaddr) >= 16 ? 2'h2 : 2'h0))
    else $error("write response code wrong");
  a_rd_code: assert property (s_rd_take |=> s_axi_rresp == ($past(s_axi_araddr) >= 16 ? 2'h2 : 2'h0))
    else $error("read response code wrong");
  a_hole_zero: assert property (s_rd_take ##0 s_axi_araddr >= 16 |=> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  a_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_quiet_start: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !irq_req)
    else $error("outputs busy after reset");
endmodule : crt_timer_checker

bind crt_timer crt_timer_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// file: tb/crt_pin_model.sv
// trigger pin source that keeps every level a minimum time
`timescale 1ns/10ps
module crt_pin_model #(
  parameter int HOLD = 2
) (
  // clock
  input wire logic clk_sys,
  // requested and driven level
  input wire logic want,
  output logic trigger_pin
);
  int age = 0;
  initial trigger_pin = 1'h1;
  // a change waits until the old level stood long enough to be sampled
  always @(posedge clk_sys) begin
    age <= age + 1;
    if (want != trigger_pin && age >= HOLD - 1) begin
      trigger_pin <= want;
      age <= 0;
    end
  end
endmodule : crt_pin_model

// file: tb/tb.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/10ps
`include "crt_params.svh"
module tb;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_rready = 1'h0, want = 1'h1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req, trigger_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, lresp;
  logic [31:0] s_axi_rdata, rdv, hold;
  int err_count = 0, n_tests = 0, cyc = 0;

  crt_timer DUT (.*);
  crt_pin_model #(.HOLD(3)) u_pin (.clk_sys, .want, .trigger_pin);

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic summarize;
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic lim(input int n, input int m);
    if (n >= m) begin
      err_count++;
      $display("[FAIL] %0t wait for the design timed out", $time);
      summarize();
    end
  endtask : lim

  // ready is raised only once the answer is seen, so every answer is held one cycle
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'h1 && ++n < 50);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1 && ++n < 50);
    s_axi_bready <= 1'h1;
    @(posedge clk_sys);
    lresp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    lim(n, 50);
  endtask : wr

  task automatic rd(input logic [4:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'h1 && ++n < 50);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1 && ++n < 50);
    s_axi_rready <= 1'h1;
    @(posedge clk_sys);
    rdv = s_axi_rdata;
    lresp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    lim(n, 50);
  endtask : rd

  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rc

  task automatic wt(input logic lv);
    int n;
    n = 0;
    do @(posedge clk_sys); while (irq_req !== lv && ++n < 70000);
    lim(n, 70000);
  endtask : wt

  // pin fall with the timer stopped, then one register and the flags
  task automatic trg(input logic [31:0] md, ct, cn, rl, input logic [4:0] a, input logic [31:0] ex, ec,
                     input logic ei);
    wr(`CRT_OFF_CTRL, 32'h0);
    wr(`CRT_OFF_MODE, md);
    wr(`CRT_OFF_COUNT, cn);
    wr(`CRT_OFF_RELOAD, rl);
    wr(`CRT_OFF_CTRL, ct);
    want <= 1'h0;
    repeat (8) @(posedge clk_sys);
    rc(a, ex);
    rc(`CRT_OFF_CTRL, ec);
    chk({31'h0, irq_req}, {31'h0, ei});
    want <= 1'h1;
    repeat (4) @(posedge clk_sys);
  endtask : trg

  // cycles between two flag events, flags read after the first
  task automatic per(input logic [31:0] md, rl, cn, input int ex, input logic [4:0] cx);
    int t0;
    wr(`CRT_OFF_CTRL, 32'h0);
    wr(`CRT_OFF_MODE, md);
    wr(`CRT_OFF_RELOAD, rl);
    wr(`CRT_OFF_COUNT, cn);
    wr(`CRT_OFF_CTRL, {29'h0, cx[2:0]});
    wt(1'h1);
    t0 = cyc;
    rc(`CRT_OFF_CTRL, {27'h0, cx});
    // keep the external flag: in dual-slope use it is the count direction
    wr(`CRT_OFF_CTRL, {27'h0, cx[4], 1'h0, cx[2:0]});
    wt(1'h0);
    wt(1'h1);
    chk(32'(cyc - t0), 32'(ex));
  endtask : per

  // new top written mid-period only takes effect from the following period
  task automatic dbl(input logic [31:0] rl, p0, p1);
    logic [31:0] t;
    t = 32'(cyc);
    wr(`CRT_OFF_RELOAD, rl);
    wr(`CRT_OFF_CTRL, 32'h01);
    wt(1'h0);
    wt(1'h1);
    chk(32'(cyc) - t, p0);
    t = 32'(cyc);
    wr(`CRT_OFF_CTRL, 32'h01);
    wt(1'h0);
    wt(1'h1);
    chk(32'(cyc) - t, p1);
  endtask : dbl

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 16; i += 4) rc(5'(i), 32'h0);
    wr(5'h10, 32'hffff);
    chk({30'h0, lresp}, {30'h0, `CRT_RESP_SLVERR});
    rd(5'h14);
    chk(rdv | {30'h0, lresp}, {30'h0, `CRT_RESP_SLVERR});
    wr(`CRT_OFF_MODE, 32'h0f07);
    rc(`CRT_OFF_MODE, 32'h0f07);
    trg(32'h0, 32'h02, 32'h1234, 32'h0, `CRT_OFF_RELOAD, 32'h0, 32'h02, 1'h0);
    trg(32'h0, 32'h06, 32'h1234, 32'h0, `CRT_OFF_RELOAD, 32'h1234, 32'h16, 1'h1);
    trg(32'h0, 32'h04, 32'h5, 32'habcd, `CRT_OFF_COUNT, 32'habcd, 32'h14, 1'h1);
    trg(32'h1, 32'h04, 32'h77, 32'hff, `CRT_OFF_COUNT, 32'h0, 32'h14, 1'h1);
    per(32'h0100, 32'hfff0, 32'hfff0, 32, 5'h09);
    per(32'h0201, 32'h9, 32'h0, 30, 5'h09);
    dbl(32'h4, 32'h1e, 32'hf);
    per(32'h0002, 32'hc, 32'h0, 24, 5'h09);
    dbl(32'h4, 32'h18, 32'h8);
    per(32'h0003, 32'hc, 32'h0, 12, 5'h19);
    want <= 1'h0;
    per(32'h0006, 32'hc, 32'h0, 24, 5'h09);
    per(32'h0104, 32'hfff0, 32'hffff, 32, 5'h19);
    per(32'h0205, 32'h9, 32'h9, 30, 5'h19);
    want <= 1'h1;
    per(32'h0205, 32'h9, 32'h0, 30, 5'h19);
    per(32'h0, 32'h0, 32'hff00, 65536, 5'h0b);
    wr(`CRT_OFF_CTRL, 32'h0);
    rd(`CRT_OFF_COUNT);
    hold = rdv;
    repeat (6) @(posedge clk_sys);
    rc(`CRT_OFF_COUNT, hold);
    summarize();
  end

  // full run is about 67000 cycles
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_count++;
    $display("[FAIL] %0t run timed out", $time);
    summarize();
  end
endmodule : tb
